// ===== hdl/tsf_defines.svh
// Purpose: Constants of the time slice framer
// Assumes: Included by its bare name
// Notes:   Offsets are byte positions in the outgoing frame
`ifndef TSF_DEFINES_SVH
`define TSF_DEFINES_SVH

`define TSF_CLK_NS       8
`define TSF_US_NS        1000
`define TSF_US_CYCLES    (`TSF_US_NS / `TSF_CLK_NS)
`define TSF_HDR_LEN      42
`define TSF_PKG_LEN      9
`define TSF_OFS_IPLEN    16
`define TSF_OFS_IPID     18
`define TSF_OFS_IPCSUM   24
`define TSF_OFS_UDPLEN   38
`define TSF_OFS_UDPCSUM  40
`define TSF_IP_FIRST     14
`define TSF_IPLEN_BASE   16'h001C
`define TSF_UDPLEN_BASE  16'h0008
`define TSF_ETYPE_IP     16'h0800
`define TSF_IP_VERIHL    8'h45
`define TSF_IP_FLAGS     16'h4000
`define TSF_IP_TTL       8'h40
`define TSF_IP_UDP       8'h11
`define TSF_FIFO_DEPTH   32
`define TSF_FIFO_MARGIN  2

`endif

// ===== hdl/tsf_framer.sv
// Purpose: Chain framer: slice generator, frame forwarding, data package insertion
// Assumes: Frames enter as bytes with last marker; no preamble or FCS handled here
// Notes:   UDP checksum is sent as zero, which IPv4 allows
`timescale 1ns/10ps
`default_nettype none
`include "tsf_defines.svh"

// ****************************************
// Output FIFO
// ****************************************
module tsf_fifo #(
  parameter int W = 9,
  parameter int D = 32
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic                 inValid,
  input  wire logic [W-1:0]         inData,
  output logic                      inReady,
  output logic                      outValid,
  output logic [W-1:0]              outData,
  input  wire logic                 outReady,
  output logic [$clog2(D+1)-1:0]    count
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [$clog2(D+1)-1:0] cnt_q;
  logic push;
  logic pop;

  assign inReady  = (cnt_q != D[$clog2(D+1)-1:0]);
  assign outValid = (cnt_q != '0);
  assign outData  = mem_q[rdPtr_q];
  assign count    = cnt_q;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q   <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : tsf_fifo

module tsf_framer import tsf_pkg::*; #(
  parameter logic [47:0] DST_MAC   = 48'hFFFFFFFFFFFF,
  parameter logic [47:0] CHAIN_MAC = 48'h020000000001,
  parameter logic [31:0] SRC_IP    = 32'h0A000001,
  parameter logic [31:0] DST_IP    = 32'h0A000002,
  parameter logic [15:0] SRC_PORT  = 16'h1000,
  parameter logic [15:0] DST_PORT  = 16'h1000,
  parameter int          DEPTH     = `TSF_FIFO_DEPTH
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        isLastPin,
  input  wire logic        linkUpPin,
  input  wire logic        tbSyncPin,
  input  wire logic [23:0] slicePeriod,
  input  wire logic [7:0]  slotDivisor,
  input  wire logic [7:0]  slotPhase,
  input  wire logic [7:0]  moduleId,
  input  wire logic        sampleValid,
  input  wire logic [31:0] sampleData,
  input  wire logic        rxValid,
  input  wire tsf_byte_t   rxByte,
  output logic             rxReady,
  output logic             txValid,
  output tsf_byte_t        txByte,
  input  wire logic        txReady,
  output logic [15:0]      sliceCount,
  output logic [31:0]      timeUs
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [6:0] US_CYC = 7'(`TSF_US_CYCLES);
  localparam logic [5:0] HDR_LAST = 6'(`TSF_HDR_LEN - 1);
  localparam logic [5:0] PKG_LAST = 6'(`TSF_PKG_LEN - 1);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] tplByte(input logic [5:0] i, input logic [15:0] slice);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      6'd0, 6'd1, 6'd2, 6'd3, 6'd4, 6'd5: b = DST_MAC[8'(47 - 8 * i) -: 8];
      6'd6, 6'd7, 6'd8, 6'd9, 6'd10, 6'd11: b = CHAIN_MAC[8'(95 - 8 * i) -: 8];
      6'd12: b = 8'(`TSF_ETYPE_IP >> 8);
      6'd13: b = 8'(`TSF_ETYPE_IP);
      6'd14: b = `TSF_IP_VERIHL;
      6'd16: b = 8'(`TSF_IPLEN_BASE >> 8);
      6'd17: b = 8'(`TSF_IPLEN_BASE);
      6'd18: b = slice[15:8];
      6'd19: b = slice[7:0];
      6'd20: b = 8'(`TSF_IP_FLAGS >> 8);
      6'd22: b = `TSF_IP_TTL;
      6'd23: b = `TSF_IP_UDP;
      6'd26, 6'd27, 6'd28, 6'd29: b = SRC_IP[8'(239 - 8 * i) -: 8];
      6'd30, 6'd31, 6'd32, 6'd33: b = DST_IP[8'(271 - 8 * i) -: 8];
      6'd34: b = SRC_PORT[15:8];
      6'd35: b = SRC_PORT[7:0];
      6'd36: b = DST_PORT[15:8];
      6'd37: b = DST_PORT[7:0];
      6'd38: b = 8'(`TSF_UDPLEN_BASE >> 8);
      6'd39: b = 8'(`TSF_UDPLEN_BASE);
      default: b = 8'h00;
    endcase
    return b;
  endfunction : tplByte

  function automatic logic slotMatch(input logic [15:0] slice, input logic [7:0] div,
                                     input logic [7:0] ph);
    logic [15:0] r;
    r = (div == 8'h00) ? 16'h0000 : slice % {8'h00, div};
    return r == {8'h00, ph};
  endfunction : slotMatch

  // ****************************************
  // Pin synchronisers and time base
  // ****************************************
  logic [1:0] lastSync_q;
  logic [1:0] linkSync_q;
  logic [2:0] tbSync_q;
  logic       genOn;
  logic       tbEdge;
  logic [6:0] usDiv_q;
  logic [31:0] timeUs_q;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      lastSync_q <= '0;
      linkSync_q <= '0;
      tbSync_q   <= '0;
    end else begin
      lastSync_q <= {lastSync_q[0], isLastPin};
      linkSync_q <= {linkSync_q[0], linkUpPin};
      tbSync_q   <= {tbSync_q[1:0], tbSyncPin};
    end
  end

  assign genOn  = lastSync_q[1] && linkSync_q[1];
  assign tbEdge = tbSync_q[1] && !tbSync_q[2];

  // Restarting on the shared line removes offset and drift alike
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      usDiv_q  <= '0;
      timeUs_q <= '0;
    end else if (tbEdge) begin
      usDiv_q  <= '0;
      timeUs_q <= '0;
    end else if (usDiv_q == US_CYC - 7'd1) begin
      usDiv_q  <= '0;
      timeUs_q <= timeUs_q + 32'd1;
    end else begin
      usDiv_q <= usDiv_q + 7'd1;
    end
  end

  logic [31:0] smpData_q;
  logic [31:0] smpTime_q;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      smpData_q <= '0;
      smpTime_q <= '0;
    end else if (sampleValid) begin
      smpData_q <= sampleData;
      smpTime_q <= timeUs_q;
    end
  end

  // ****************************************
  // Slice generator
  // ****************************************
  logic [23:0] sliceTmr_q;
  logic [15:0] sliceCnt_q;
  logic        tick;
  logic        pending_q;
  tsf_state_t  state_q;
  tsf_state_t  stateNext;

  // Period 0 or 1 ticks every cycle instead of wrapping the compare
  assign tick = genOn && (slicePeriod <= 24'd1 || sliceTmr_q >= slicePeriod - 24'd1);

  always_ff @(posedge mclk) begin
    if (!rst_b || !genOn) begin
      sliceTmr_q <= '0;
      sliceCnt_q <= '0;
    end else if (tick) begin
      sliceTmr_q <= '0;
      sliceCnt_q <= sliceCnt_q + 16'd1;
    end else begin
      sliceTmr_q <= sliceTmr_q + 24'd1;
    end
  end

  // A tick during the clear is kept so no slice is lost
  always_ff @(posedge mclk) begin
    if (!rst_b) pending_q <= 1'b0;
    else if (tick) pending_q <= 1'b1;
    else if (state_q == ST_GEN) pending_q <= 1'b0;
  end

  // ****************************************
  // Frame path
  // ****************************************
  logic [7:0]  hdr_q [`TSF_HDR_LEN];
  logic [5:0]  idx_q;
  logic        insert_q;
  logic        gen_q;
  logic        hdrEnd_q;
  logic        rxReady_q;
  logic        rxTake;
  logic        fInValid;
  tsf_byte_t   fInData;
  logic        fInReady;
  logic        fOutValid;
  tsf_byte_t   fOutData;
  logic        fPop;
  logic [CW-1:0] fCount;
  logic [15:0] rxSlice;
  logic [31:0] sum;
  logic [7:0]  pkgByte;
  logic        room;

  assign rxTake  = rxValid && rxReady_q;
  assign rxSlice = {hdr_q[`TSF_OFS_IPID], hdr_q[`TSF_OFS_IPID + 1]};
  assign room    = fCount < CW'(DEPTH - `TSF_FIFO_MARGIN);

  always_comb begin
    sum = 32'h0;
    for (int k = `TSF_IP_FIRST; k < `TSF_OFS_IPLEN + 18; k = k + 2) begin
      sum = sum + {16'h0, hdr_q[k], hdr_q[k + 1]};
    end
    sum = {16'h0, sum[15:0]} + {16'h0, sum[31:16]};
    sum = {16'h0, sum[15:0]} + {16'h0, sum[31:16]};
  end

  always_comb begin
    case (idx_q[3:0])
      4'd0: pkgByte = moduleId;
      4'd1: pkgByte = smpTime_q[31:24];
      4'd2: pkgByte = smpTime_q[23:16];
      4'd3: pkgByte = smpTime_q[15:8];
      4'd4: pkgByte = smpTime_q[7:0];
      4'd5: pkgByte = smpData_q[31:24];
      4'd6: pkgByte = smpData_q[23:16];
      4'd7: pkgByte = smpData_q[15:8];
      default: pkgByte = smpData_q[7:0];
    endcase
  end

  always_comb begin
    stateNext = state_q;
    case (state_q)
      ST_HDR: begin
        if (lastSync_q[1] && pending_q && idx_q == 6'd0) stateNext = ST_GEN;
        else if (rxTake && idx_q == HDR_LAST) stateNext = ST_FIX;
      end
      ST_GEN:  stateNext = ST_FIX;
      ST_FIX:  stateNext = ST_SUM;
      ST_SUM:  stateNext = ST_PUT;
      ST_PUT: begin
        if (fInReady && idx_q == HDR_LAST) begin
          stateNext = (gen_q || hdrEnd_q) ? (insert_q ? ST_PKG : ST_HDR) : ST_BODY;
        end
      end
      ST_BODY: begin
        if (rxTake && rxByte.last) stateNext = insert_q ? ST_PKG : ST_HDR;
      end
      ST_PKG: begin
        if (fInReady && idx_q == PKG_LAST) stateNext = ST_HDR;
      end
      default: stateNext = ST_HDR;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) state_q <= ST_HDR;
    else state_q <= stateNext;
  end

  // Registered ready; the FIFO margin absorbs the byte taken after it drops
  always_ff @(posedge mclk) begin
    if (!rst_b) rxReady_q <= 1'b0;
    else rxReady_q <= !lastSync_q[1] && room && (stateNext == ST_HDR || stateNext == ST_BODY);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      idx_q <= '0;
    end else if (stateNext != state_q) begin
      idx_q <= '0;
    end else if ((state_q == ST_HDR && rxTake) ||
                 ((state_q == ST_PUT || state_q == ST_PKG) && fInReady)) begin
      idx_q <= idx_q + 6'd1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      insert_q <= 1'b0;
      gen_q    <= 1'b0;
    end else if (state_q == ST_GEN) begin
      gen_q    <= 1'b1;
      insert_q <= slotMatch(sliceCnt_q, slotDivisor, slotPhase);
    end else if (state_q == ST_FIX && !gen_q) begin
      insert_q <= slotMatch(rxSlice, slotDivisor, slotPhase);
    end else if (stateNext == ST_HDR) begin
      gen_q <= 1'b0;
    end
  end

  // Bare header frame: its end marker sits on the last header byte
  always_ff @(posedge mclk) begin
    if (!rst_b) hdrEnd_q <= 1'b0;
    else if (state_q == ST_HDR && rxTake && idx_q == HDR_LAST) hdrEnd_q <= rxByte.last;
  end

  // Lengths grow by one package per inserting module
  always_ff @(posedge mclk) begin
    if (state_q == ST_GEN) begin
      for (int i = 0; i < `TSF_HDR_LEN; i++) hdr_q[i] <= tplByte(6'(i), sliceCnt_q);
    end else if (state_q == ST_HDR && rxTake) begin
      hdr_q[idx_q] <= rxByte.data;
    end else if (state_q == ST_FIX) begin
      if (gen_q ? slotMatch(sliceCnt_q, slotDivisor, slotPhase) :
                  slotMatch(rxSlice, slotDivisor, slotPhase)) begin
        {hdr_q[`TSF_OFS_IPLEN], hdr_q[`TSF_OFS_IPLEN + 1]} <=
          {hdr_q[`TSF_OFS_IPLEN], hdr_q[`TSF_OFS_IPLEN + 1]} + 16'(`TSF_PKG_LEN);
        {hdr_q[`TSF_OFS_UDPLEN], hdr_q[`TSF_OFS_UDPLEN + 1]} <=
          {hdr_q[`TSF_OFS_UDPLEN], hdr_q[`TSF_OFS_UDPLEN + 1]} + 16'(`TSF_PKG_LEN);
      end
      {hdr_q[`TSF_OFS_IPCSUM], hdr_q[`TSF_OFS_IPCSUM + 1]}   <= 16'h0000;
      {hdr_q[`TSF_OFS_UDPCSUM], hdr_q[`TSF_OFS_UDPCSUM + 1]} <= 16'h0000;
    end else if (state_q == ST_SUM) begin
      {hdr_q[`TSF_OFS_IPCSUM], hdr_q[`TSF_OFS_IPCSUM + 1]} <= ~sum[15:0];
    end
  end

  always_comb begin
    fInValid = 1'b0;
    fInData  = '{data: 8'h00, last: 1'b0};
    case (state_q)
      ST_PUT: begin
        fInValid = 1'b1;
        fInData  = '{data: hdr_q[idx_q], last: (gen_q || hdrEnd_q) && !insert_q && idx_q == HDR_LAST};
      end
      ST_BODY: begin
        fInValid = rxTake;
        fInData  = '{data: rxByte.data, last: rxByte.last && !insert_q};
      end
      ST_PKG: begin
        fInValid = 1'b1;
        fInData  = '{data: pkgByte, last: idx_q == PKG_LAST};
      end
      default: fInValid = 1'b0;
    endcase
  end

  tsf_fifo #(.W($bits(tsf_byte_t)), .D(DEPTH)) uFifo (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .inValid  (fInValid),
    .inData   (fInData),
    .inReady  (fInReady),
    .outValid (fOutValid),
    .outData  (fOutData),
    .outReady (fPop),
    .count    (fCount)
  );

  // ****************************************
  // Output stage
  // ****************************************
  logic      txValid_q;
  tsf_byte_t txByte_q;

  assign fPop = fOutValid && (!txValid_q || txReady);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      txValid_q <= 1'b0;
      txByte_q  <= '0;
    end else if (!txValid_q || txReady) begin
      txValid_q <= fOutValid;
      txByte_q  <= fOutData;
    end
  end

  assign rxReady    = rxReady_q;
  assign txValid    = txValid_q;
  assign txByte     = txByte_q;
  assign sliceCount = sliceCnt_q;
  assign timeUs     = timeUs_q;

endmodule : tsf_framer
`default_nettype wire

// ===== hdl/tsf_pkg.sv
// Purpose: Types of the time slice framer
// Assumes: Nothing
// Notes:   Byte stream carries its own end marker
package tsf_pkg;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } tsf_byte_t;

  typedef enum logic [2:0] {
    ST_HDR  = 3'b000,
    ST_GEN  = 3'b001,
    ST_FIX  = 3'b010,
    ST_SUM  = 3'b011,
    ST_PUT  = 3'b100,
    ST_BODY = 3'b101,
    ST_PKG  = 3'b110
  } tsf_state_t;

endpackage : tsf_pkg

// ===== verif/tsf_framer_properties.sv
// Purpose: Port checks of the chain framer
// Assumes: Bound onto every framer instance
// Notes:   Level pins act only after two sync edges
`timescale 1ns/10ps
`default_nettype none
module tsf_framer_chk import tsf_pkg::*; (
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        isLastPin,
  input wire logic        linkUpPin,
  input wire logic        rxReady,
  input wire logic        txValid,
  input wire tsf_byte_t   txByte,
  input wire logic        txReady,
  input wire logic [15:0] sliceCount,
  input wire logic [31:0] timeUs
);
  logic [7:0] gapQ;
  logic [7:0] byteQ;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // ****************************************
  // Helper counters
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_b || $changed(timeUs)) begin
      gapQ <= 8'h00;
    end else if (gapQ != 8'hFF) begin
      gapQ <= gapQ + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      byteQ <= 8'h00;
    end else if (txValid && txReady) begin
      byteQ <= txByte.last ? 8'h00 : byteQ + 8'h01;
    end
  end

  sequence s_tick;
    $changed(sliceCount) && sliceCount != 16'h0000;
  endsequence
  sequence s_take_last;
    txValid && txReady && txByte.last;
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  a_reset_quiet: assert property (disable iff (1'b0)
    !rst_b |=> sliceCount == 16'h0000 && timeUs == 32'h0 && !txValid && !rxReady)
    else $error("outputs not cleared by reset");
  a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txByte))
    else $error("tx byte changed before taken");
  a_slice_step: assert property ($changed(sliceCount) |->
    sliceCount == 16'($past(sliceCount) + 16'h0001) || sliceCount == 16'h0000)
    else $error("slice counter skipped");
  a_link_clears: assert property ((!linkUpPin) [*5] |-> sliceCount == 16'h0000)
    else $error("slice counter runs without link");
  a_last_closed: assert property (isLastPin [*5] |-> !rxReady)
    else $error("last module accepts rx bytes");
  a_time_step: assert property ($changed(timeUs) |->
    timeUs == $past(timeUs) + 32'h1 || timeUs == 32'h0)
    else $error("time base jumped");
  a_time_rate: assert property ($changed(timeUs) && timeUs != 32'h0 && $past(timeUs) != 32'h0
    |-> gapQ == 8'h7C)
    else $error("microsecond step not 125 cycles");
  a_gen_frame: assert property (s_tick |-> ##[1:60] txValid)
    else $error("no frame after slice tick");
  a_frame_min: assert property (s_take_last |-> byteQ >= 8'h29)
    else $error("frame shorter than header");
endmodule : tsf_framer_chk

bind tsf_framer tsf_framer_chk u_chk (.mclk(mclk), .rst_b(rst_b), .isLastPin(isLastPin),
  .linkUpPin(linkUpPin), .rxReady(rxReady), .txValid(txValid), .txByte(txByte),
  .txReady(txReady), .sliceCount(sliceCount), .timeUs(timeUs));
`default_nettype wire

// ===== verif/tsf_pc_model.sv
// Purpose: Master side sink that captures frames
// Assumes: mode 0 ready, 1 stalls every other cycle, 2 holds
// Notes:   Keeps only the newest frame
`timescale 1ns/10ps
`default_nettype none
module tsf_pc_model import tsf_pkg::*; (
  input  wire logic       mclk,
  input  wire logic [1:0] mode,
  input  wire logic       txValid,
  input  wire tsf_byte_t  txByte,
  output logic            txReady
);
  logic [7:0] mem [0:127];
  int         cnt = 0;
  int         len = 0;
  int         frames = 0;

  initial txReady = 1'b0;

  // Master never requests data, it only paces acceptance
  always @(negedge mclk) begin
    txReady <= (mode == 2'h0) || (mode == 2'h1 && !txReady);
  end

  always @(posedge mclk) begin
    if (txValid && txReady) begin
      mem[cnt[6:0]] <= txByte.data;
      cnt <= txByte.last ? 0 : cnt + 1;
      if (txByte.last) begin
        len <= cnt + 1;
        frames <= frames + 1;
      end
    end
  end
endmodule : tsf_pc_model
`default_nettype wire

// ===== verif/tsf_testbench.sv
// Purpose: Self-checking bench of the chain framer
// Assumes: Inputs change on the falling edge
// Notes:   Frames are judged as the master model captured them
`timescale 1ns/10ps
`default_nettype none
`include "tsf_defines.svh"
module testbench;
  localparam logic [47:0] CHAIN = 48'h020000000001;
  logic mclk = 1'b0, rst_b = 1'b0, isLastPin = 1'b0, linkUpPin = 1'b0, tbSyncPin = 1'b0;
  logic [23:0] slicePeriod = 24'h00012C;
  logic [7:0] slotDivisor = 8'h01, slotPhase = 8'h00, moduleId = 8'h5A;
  logic sampleValid = 1'b0, rxValid = 1'b0, rxReady, txValid, txReady;
  logic [31:0] sampleData = 32'hA5C31E77, timeUs;
  tsf_pkg::tsf_byte_t rxByte = '0, txByte;
  logic [15:0] sliceCount;
  logic [1:0] mode = 2'h0;
  int err_total = 0, checked = 0;
  logic [31:0] stamp = 32'h0;

  always #4 mclk = ~mclk;

  tsf_framer #(.CHAIN_MAC(CHAIN)) DUT (.mclk(mclk), .rst_b(rst_b), .isLastPin(isLastPin),
    .linkUpPin(linkUpPin), .tbSyncPin(tbSyncPin), .slicePeriod(slicePeriod),
    .slotDivisor(slotDivisor), .slotPhase(slotPhase), .moduleId(moduleId),
    .sampleValid(sampleValid), .sampleData(sampleData), .rxValid(rxValid), .rxByte(rxByte),
    .rxReady(rxReady), .txValid(txValid), .txByte(txByte), .txReady(txReady),
    .sliceCount(sliceCount), .timeUs(timeUs));
  tsf_pc_model pc (.mclk(mclk), .mode(mode), .txValid(txValid), .txByte(txByte), .txReady(txReady));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  function automatic logic [15:0] w16(input int o);
    return {pc.mem[o], pc.mem[o+1]};
  endfunction : w16

  task automatic wait_frame(input int n0);
    int k;
    k = 0;
    while (pc.frames == n0 && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    cmp(48'(pc.frames != n0), 48'h1);
  endtask : wait_frame

  task automatic chk_frame(input logic [15:0] id, input int nb, input logic pkg);
    int n;
    int s;
    n = pkg ? `TSF_PKG_LEN : 0;
    s = 0;
    cmp(48'(pc.len), 48'(`TSF_HDR_LEN + nb + n));
    cmp(48'(w16(`TSF_OFS_IPID)), 48'(id));
    cmp(48'(w16(`TSF_OFS_IPLEN)), 48'(`TSF_IPLEN_BASE + nb + n));
    cmp(48'(w16(`TSF_OFS_UDPLEN)), 48'(`TSF_UDPLEN_BASE + nb + n));
    cmp(48'(w16(12)), 48'(`TSF_ETYPE_IP));
    for (int i = `TSF_IP_FIRST; i < `TSF_IP_FIRST + 20; i += 2) s += w16(i);
    s = (s & 32'hFFFF) + (s >> 16);
    s = (s & 32'hFFFF) + (s >> 16);
    cmp(48'(s), 48'hFFFF);
    if (pkg) begin
      cmp(48'(pc.mem[42 + nb]), 48'(moduleId));
      cmp(48'({w16(43 + nb), w16(45 + nb)}), 48'(stamp));
      cmp(48'({w16(47 + nb), w16(49 + nb)}), 48'(sampleData));
    end
  endtask : chk_frame

  task automatic send_frame(input logic [15:0] id, input int nb);
    logic [7:0] b;
    int k;
    for (int i = 0; i < `TSF_HDR_LEN + nb; i++) begin
      case (i)
        12: b = 8'h08;
        13: b = 8'h00;
        14: b = `TSF_IP_VERIHL;
        16: b = 8'h00;
        17: b = 8'(`TSF_IPLEN_BASE + nb);
        18: b = id[15:8];
        19: b = id[7:0];
        23: b = `TSF_IP_UDP;
        38: b = 8'h00;
        39: b = 8'(`TSF_UDPLEN_BASE + nb);
        default: b = 8'(i);
      endcase
      rxValid <= 1'b1;
      rxByte <= '{data: b, last: (i == `TSF_HDR_LEN + nb - 1)};
      k = 0;
      // Ready stands from one rising edge to the next, so look at it here
      while (!rxReady && k < 3000) begin
        @(negedge mclk);
        k++;
      end
      if (k >= 3000) err_total++;
      @(negedge mclk);
    end
    rxValid <= 1'b0;
  endtask : send_frame

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    repeat (2) @(negedge mclk);
    cmp({sliceCount, timeUs}, 48'h0);
    cmp({txValid, rxReady}, 48'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_sync;
    repeat (300) @(negedge mclk);
    tbSyncPin <= 1'b1;
    repeat (10) @(negedge mclk);
    cmp(48'(timeUs), 48'h0);
    repeat (375) @(negedge mclk);
    cmp(48'(timeUs), 48'h3);
    tbSyncPin <= 1'b0;
    $display("test sync done");
  endtask : t_sync

  task automatic t_gen;
    int n0;
    logic [15:0] id, prev;
    slotDivisor <= 8'h02;
    sampleValid <= 1'b1;
    stamp = timeUs;
    @(negedge mclk);
    sampleValid <= 1'b0;
    mode <= 2'h1;
    isLastPin <= 1'b1;
    linkUpPin <= 1'b1;
    for (int f = 0; f < 4; f++) begin
      n0 = pc.frames;
      wait_frame(n0);
      id = w16(`TSF_OFS_IPID);
      chk_frame(id, 0, !id[0]);
      cmp(48'(sliceCount), 48'(id));
      cmp({w16(6), w16(8), w16(10)}, CHAIN);
      if (f > 0) cmp(48'(id), 48'(prev + 16'h0001));
      prev = id;
    end
    isLastPin <= 1'b0;
    repeat (300) @(negedge mclk);
    n0 = pc.frames;
    repeat (700) @(negedge mclk);
    cmp({16'(pc.frames - n0), sliceCount}, 48'h0);
    isLastPin <= 1'b1;
    linkUpPin <= 1'b0;
    repeat (700) @(negedge mclk);
    cmp({16'(pc.frames - n0), sliceCount}, 48'h0);
    $display("test generator done");
  endtask : t_gen

  task automatic t_fwd;
    int n0;
    logic [15:0] ids [3] = '{16'h0003, 16'h0004, 16'hFFFD};
    isLastPin <= 1'b0;
    linkUpPin <= 1'b1;
    mode <= 2'h0;
    slotDivisor <= 8'h05;
    slotPhase <= 8'h03;
    for (int f = 0; f < 3; f++) begin
      n0 = pc.frames;
      send_frame(ids[f], 4);
      wait_frame(n0);
      chk_frame(ids[f], 4, ids[f] % 16'h0005 == 16'h0003);
      cmp(48'(pc.mem[42]), 48'h2A);
    end
    // Bare header frames, without and with a package
    for (int f = 0; f < 2; f++) begin
      n0 = pc.frames;
      send_frame(16'h000C + 16'(f), 0);
      wait_frame(n0);
      chk_frame(16'h000C + 16'(f), 0, f == 1);
    end
    n0 = pc.frames;
    mode <= 2'h2;
    fork
      send_frame(16'h0008, 60);
      begin
        repeat (300) @(negedge mclk);
        cmp(48'(rxReady), 48'h0);
        mode <= 2'h0;
      end
    join
    wait_frame(n0);
    chk_frame(16'h0008, 60, 1'b1);
    cmp(48'(pc.mem[100]), 48'h64);
    $display("test forward done");
  endtask : t_fwd

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    print_verdict;
  end

  initial begin
    repeat (5) @(negedge mclk);
    rst_b <= 1'b1;
    t_reset;
    t_sync;
    t_gen;
    t_fwd;
    rst_b <= 1'b0;
    repeat (5) @(negedge mclk);
    rst_b <= 1'b1;
    t_reset;
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
